// File: din_decode.sv
`timescale 1ns/1ps
`include "pump_fill_map.svh"
// per terminal function decode; terminal 4 is the coast terminal
module din_decode
   import pump_fill_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  din,
   input  wire logic [31:0] func,
   output logic             reset_pulse,
   output logic             coast_req,
   output logic             brake_req,
   output logic             interlock_req,
   output logic             freeze_ref,
   output logic             freeze_out,
   output logic             setup_lsb
);
   logic [7:0] prev_r, prev_nxt;
   logic [7:0] rst_v, coast_v, brake_v, lock_v, fref_v, fout_v, setup_v;
   // a literal cannot be bit-selected, so the option mask gets a name
   localparam logic [7:0] SETUP_MASK = `SETUP_LSB_MASK;

   for (genvar i = 0; i < 8; i++) begin : g_term
      logic [3:0] code;
      assign code = func[4*i +: 4];
      if (i == 4) begin : g_coast
         assign coast_v[i] = !din[i] && (code == CF_COAST_INV || code == CF_RESET_COAST
                                         || code == CF_INTERLOCK);
         assign rst_v[i]   = (code == CF_RESET_COAST) && prev_r[i] && !din[i];
         assign brake_v[i] = (code == CF_DC_BRAKE) && !din[i];
         assign lock_v[i]  = (code == CF_INTERLOCK) && !din[i];
         assign fref_v[i]  = 1'b0;
         assign fout_v[i]  = 1'b0;
         assign setup_v[i] = 1'b0;
      end else begin : g_gen
         // general codes, reset on rising edge
         assign rst_v[i]   = (code == GF_RESET) && din[i] && !prev_r[i];
         assign fref_v[i]  = (code == GF_FREEZE_REF) && din[i];
         assign fout_v[i]  = (code == GF_FREEZE_OUT) && din[i];
         assign setup_v[i] = (code == GF_SETUP_LSB) && SETUP_MASK[i] && din[i];
         assign coast_v[i] = 1'b0;
         assign brake_v[i] = 1'b0;
         assign lock_v[i]  = 1'b0;
      end
   end

   assign prev_nxt = din;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_r <= 8'hFF;
      end else begin
         prev_r <= prev_nxt;
      end
   end

   // combined function levels and reset pulse
   assign reset_pulse   = |rst_v;
   assign coast_req     = |coast_v;
   assign brake_req     = |brake_v;
   assign interlock_req = |lock_v;
   assign freeze_ref    = |fref_v;
   assign freeze_out    = |fout_v;
   assign setup_lsb     = |setup_v;
endmodule : din_decode

// File: pump_fill_map.svh
`ifndef PUMP_FILL_MAP_SVH
`define PUMP_FILL_MAP_SVH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_INIT_TIME   8'h04
`define OFS_RAMP_TIME   8'h08
`define OFS_FREQ_REF    8'h0C
`define OFS_MIN_FREQ    8'h10
`define OFS_PID_FREQ    8'h14
`define OFS_FILL_RATE   8'h18
`define OFS_FILLED_SP   8'h1C
`define OFS_FB_MIN      8'h20
`define OFS_REF_MAX     8'h24
`define OFS_SETPOINT1   8'h28
`define OFS_SETPOINT2   8'h2C
`define OFS_DIN_FUNC    8'h30
`define OFS_STATUS      8'h34
`define OFS_FREQ_OUT    8'h38
`define OFS_SP_OUT      8'h3C

// control field positions
`define CTRL_RUN        0
`define CTRL_CLOSED     1
`define CTRL_NORMAL     2
`define CTRL_SP_SEL     3

// reset values
`define RST_CTRL        32'h0000_0004
`define RST_DIN_FUNC    32'h0003_1121
`define RST_RAMP_TIME   16'h0064
`define RST_MIN_FREQ    16'h0064
`define RST_WORD        32'h0000_0000

// limits
`define INIT_TIME_MAX   16'h0E10
`define FILL_RATE_MAX   32'h3B9A_C9FF
`define FREQ_FULL       32'h0000_04B0
`define SETUP_LSB_MASK  8'h61

// timing
`define CLK_HZ          10000000
`define TIME_LSB_MS     100
`define TIME_LSB_CYC    (`CLK_HZ / 1000 * `TIME_LSB_MS)

`endif

// File: pump_fill_pkg.sv
package pump_fill_pkg;

   // sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_INIT = 5'b00010,
      ST_RAMP = 5'b00100,
      ST_FILL = 5'b01000,
      ST_RUN  = 5'b10000
   } seq_state_t;

   // coast terminal function codes
   typedef enum logic [3:0] {
      CF_COAST_INV  = 4'h0,
      CF_RESET_COAST = 4'h1,
      CF_DC_BRAKE   = 4'h2,
      CF_INTERLOCK  = 4'h3
   } coast_func_t;

   // general purpose terminal function codes
   typedef enum logic [3:0] {
      GF_NONE       = 4'h0,
      GF_RESET      = 4'h1,
      GF_FREEZE_REF = 4'h2,
      GF_FREEZE_OUT = 4'h3,
      GF_SETUP_LSB  = 4'h4
   } gen_func_t;

endpackage : pump_fill_pkg

// File: pump_fill_ramp_control.sv
`timescale 1ns/1ps
`include "pump_fill_map.svh"
module pump_fill_ramp_control
   import pump_fill_pkg::*;
#(
   parameter logic [31:0] TENTH_CYCLES = `TIME_LSB_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   input  wire logic [7:0]  din,
   input  wire logic [31:0] feedback,
   output logic [15:0]      freq_out,
   output logic [31:0]      setpoint_out,
   output logic             fill_active,
   output logic             pid_enable,
   output logic             dc_brake,
   output logic             interlock_fault,
   output logic             setup_lsb
);
   // ****************************************
   // input synchronisers
   // ****************************************
   logic [7:0]  din_s1_r, din_s2_r;
   logic [31:0] fb_s1_r, fb_s2_r;

   // feedback is assumed slow against the clock; two stages only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         din_s1_r <= 8'hFF;
         din_s2_r <= 8'hFF;
         fb_s1_r  <= 32'h0000_0000;
         fb_s2_r  <= 32'h0000_0000;
      end else begin
         din_s1_r <= din;
         din_s2_r <= din_s1_r;
         fb_s1_r  <= feedback;
         fb_s2_r  <= fb_s1_r;
      end
   end

   // ****************************************
   // register file and AXI4-Lite slave
   // ****************************************
   logic [31:0] ctrl_r, ctrl_nxt, func_r, func_nxt;
   logic [15:0] init_r, init_nxt, ramp_r, ramp_nxt, fref_r, fref_nxt;
   logic [15:0] fmin_r, fmin_nxt, fpid_r, fpid_nxt;
   logic [31:0] rate_r, rate_nxt, filled_r, filled_nxt, fbmin_r, fbmin_nxt;
   logic [31:0] refmax_r, refmax_nxt, sp1_r, sp1_nxt, sp2_r, sp2_nxt;
   logic        aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
   logic [7:0]  aw_addr_r, aw_addr_nxt;
   logic [31:0] w_data_r, w_data_nxt, wmask, wval, rd_word;
   logic        bvalid_nxt, rvalid_nxt, rd_ok;
   logic [1:0]  bresp_nxt, rresp_nxt;
   logic [31:0] rdata_nxt, status;
   seq_state_t  state_r;

   assign awready = !aw_full_r && !bvalid;
   assign wready  = !w_full_r && !bvalid;
   assign arready = !rvalid;

   for (genvar b = 0; b < 4; b++) begin : g_strb
      assign wmask[8*b +: 8] = {8{wstrb[b]}};
   end

   // read mux; unmapped addresses answer SLVERR
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok   = 1'b1;
      if (araddr == `OFS_CTRL) begin
         rd_word = ctrl_r;
      end else if (araddr == `OFS_INIT_TIME) begin
         rd_word = {16'h0000, init_r};
      end else if (araddr == `OFS_RAMP_TIME) begin
         rd_word = {16'h0000, ramp_r};
      end else if (araddr == `OFS_FREQ_REF) begin
         rd_word = {16'h0000, fref_r};
      end else if (araddr == `OFS_MIN_FREQ) begin
         rd_word = {16'h0000, fmin_r};
      end else if (araddr == `OFS_PID_FREQ) begin
         rd_word = {16'h0000, fpid_r};
      end else if (araddr == `OFS_FILL_RATE) begin
         rd_word = rate_r;
      end else if (araddr == `OFS_FILLED_SP) begin
         rd_word = filled_r;
      end else if (araddr == `OFS_FB_MIN) begin
         rd_word = fbmin_r;
      end else if (araddr == `OFS_REF_MAX) begin
         rd_word = refmax_r;
      end else if (araddr == `OFS_SETPOINT1) begin
         rd_word = sp1_r;
      end else if (araddr == `OFS_SETPOINT2) begin
         rd_word = sp2_r;
      end else if (araddr == `OFS_DIN_FUNC) begin
         rd_word = func_r;
      end else if (araddr == `OFS_STATUS) begin
         rd_word = status;
      end else if (araddr == `OFS_FREQ_OUT) begin
         rd_word = {16'h0000, freq_out};
      end else if (araddr == `OFS_SP_OUT) begin
         rd_word = setpoint_out;
      end else begin
         rd_ok = 1'b0;
      end
   end

   // address and data are latched apart; the write lands once both are in
   always_comb begin
      aw_full_nxt = aw_full_r;
      aw_addr_nxt = aw_addr_r;
      w_full_nxt  = w_full_r;
      w_data_nxt  = w_data_r;
      bvalid_nxt  = bvalid && !bready;
      bresp_nxt   = bresp;
      rvalid_nxt  = rvalid && !rready;
      rresp_nxt   = rresp;
      rdata_nxt   = rdata;
      ctrl_nxt = ctrl_r;     func_nxt = func_r;     init_nxt = init_r;
      ramp_nxt = ramp_r;     fref_nxt = fref_r;     fmin_nxt = fmin_r;
      fpid_nxt = fpid_r;     rate_nxt = rate_r;     filled_nxt = filled_r;
      fbmin_nxt = fbmin_r;   refmax_nxt = refmax_r; sp1_nxt = sp1_r;
      sp2_nxt = sp2_r;
      wval = (w_data_r & wmask) | (rd_word & ~wmask);
      if (awvalid && awready) begin
         aw_full_nxt = 1'b1;
         aw_addr_nxt = awaddr;
      end
      if (wvalid && wready) begin
         w_full_nxt = 1'b1;
         w_data_nxt = wdata;
      end
      if (aw_full_r && w_full_r) begin
         aw_full_nxt = 1'b0;
         w_full_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = 2'b00;
         wval = w_data_r;
         if (aw_addr_r == `OFS_CTRL) begin
            ctrl_nxt = {28'h000_0000, wval[3:0]};
         end else if (aw_addr_r == `OFS_INIT_TIME) begin
            init_nxt = (wval[15:0] > `INIT_TIME_MAX) ? `INIT_TIME_MAX : wval[15:0];
         end else if (aw_addr_r == `OFS_RAMP_TIME) begin
            ramp_nxt = wval[15:0];
         end else if (aw_addr_r == `OFS_FREQ_REF) begin
            fref_nxt = wval[15:0];
         end else if (aw_addr_r == `OFS_MIN_FREQ) begin
            fmin_nxt = wval[15:0];
         end else if (aw_addr_r == `OFS_PID_FREQ) begin
            fpid_nxt = wval[15:0];
         end else if (aw_addr_r == `OFS_FILL_RATE) begin
            rate_nxt = (wval > `FILL_RATE_MAX) ? `FILL_RATE_MAX : wval;
         end else if (aw_addr_r == `OFS_FILLED_SP) begin
            filled_nxt = wval;
         end else if (aw_addr_r == `OFS_FB_MIN) begin
            fbmin_nxt = wval;
         end else if (aw_addr_r == `OFS_REF_MAX) begin
            refmax_nxt = wval;
         end else if (aw_addr_r == `OFS_SETPOINT1) begin
            sp1_nxt = wval;
         end else if (aw_addr_r == `OFS_SETPOINT2) begin
            sp2_nxt = wval;
         end else if (aw_addr_r == `OFS_DIN_FUNC) begin
            func_nxt = wval;
         end else begin
            bresp_nxt = 2'b10;
         end
      end
      if (arvalid && arready) begin
         rvalid_nxt = 1'b1;
         rdata_nxt  = rd_word;
         rresp_nxt  = rd_ok ? 2'b00 : 2'b10;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;         w_full_r <= 1'b0;
         aw_addr_r <= 8'h00;        w_data_r <= `RST_WORD;
         bvalid    <= 1'b0;         bresp    <= 2'b00;
         rvalid    <= 1'b0;         rresp    <= 2'b00;
         rdata     <= `RST_WORD;    ctrl_r   <= `RST_CTRL;
         func_r    <= `RST_DIN_FUNC;
         init_r    <= 16'h0000;     ramp_r   <= `RST_RAMP_TIME;
         fref_r    <= 16'h0000;     fmin_r   <= `RST_MIN_FREQ;
         fpid_r    <= 16'h0000;     rate_r   <= `RST_WORD;
         filled_r  <= `RST_WORD;    fbmin_r  <= `RST_WORD;
         refmax_r  <= `RST_WORD;    sp1_r    <= `RST_WORD;
         sp2_r     <= `RST_WORD;
      end else begin
         aw_full_r <= aw_full_nxt;  w_full_r <= w_full_nxt;
         aw_addr_r <= aw_addr_nxt;  w_data_r <= w_data_nxt;
         bvalid    <= bvalid_nxt;   bresp    <= bresp_nxt;
         rvalid    <= rvalid_nxt;   rresp    <= rresp_nxt;
         rdata     <= rdata_nxt;    ctrl_r   <= ctrl_nxt;
         func_r    <= func_nxt;
         init_r    <= init_nxt;     ramp_r   <= ramp_nxt;
         fref_r    <= fref_nxt;     fmin_r   <= fmin_nxt;
         fpid_r    <= fpid_nxt;     rate_r   <= rate_nxt;
         filled_r  <= filled_nxt;   fbmin_r  <= fbmin_nxt;
         refmax_r  <= refmax_nxt;   sp1_r    <= sp1_nxt;
         sp2_r     <= sp2_nxt;
      end
   end

   // ****************************************
   // input functions and rate generators
   // ****************************************
   logic        rst_pulse, coast_req, brake_req, lock_req, freeze_ref, freeze_out;
   logic        f_step, s_step, fill_en, init_on, fault_r, fault_nxt;
   logic [31:0] f_num, f_den, limit;
   logic [15:0] f_tgt;

   din_decode u_din (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .din           (din_s2_r),
      .func          (func_r),
      .reset_pulse   (rst_pulse),
      .coast_req     (coast_req),
      .brake_req     (brake_req),
      .interlock_req (lock_req),
      .freeze_ref    (freeze_ref),
      .freeze_out    (freeze_out),
      .setup_lsb     (setup_lsb)
   );

   assign init_on = (init_r != 16'h0000);
   assign fill_en = ctrl_r[`CTRL_CLOSED] && (rate_r != 32'h0000_0000) && ctrl_r[`CTRL_NORMAL];
   assign limit = (filled_r < fbmin_r) ? fbmin_r : (filled_r > refmax_r) ? refmax_r : filled_r;

   // initial rate spans zero to minimum over the set time
   always_comb begin
      if (state_r == ST_INIT) begin
         f_num = {16'h0000, fmin_r};
         f_den = 32'(init_r * TENTH_CYCLES);
         f_tgt = fmin_r;
      end else begin
         f_num = `FREQ_FULL;
         f_den = 32'(ramp_r * TENTH_CYCLES);
         f_tgt = fref_r;
      end
   end

   ramp_step u_freq_step (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (state_r != ST_IDLE && freq_out != f_tgt && !freeze_out),
      .num     (f_num),
      .den     (f_den),
      .step    (f_step)
   );

   ramp_step u_fill_step (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (state_r == ST_FILL),
      .num     (rate_r),
      .den     (32'(`CLK_HZ)),
      .step    (s_step)
   );

   // ****************************************
   // start and fill sequencer
   // ****************************************
   seq_state_t  state_nxt;
   logic [15:0] freq_nxt;
   logic [31:0] sp_nxt, sp_oper;

   assign sp_oper = ctrl_r[`CTRL_SP_SEL] ? sp2_r : sp1_r;

   // coast and brake stop the output at once; ramp-down is left outside
   always_comb begin
      state_nxt = state_r;
      freq_nxt  = freq_out;
      sp_nxt    = setpoint_out;
      fault_nxt = (fault_r && !rst_pulse) || lock_req;
      if (f_step && freq_out < f_tgt) begin
         freq_nxt = freq_out + 16'h0001;
      end else if (f_step && freq_out > f_tgt) begin
         freq_nxt = freq_out - 16'h0001;
      end
      case (state_r)
         ST_IDLE: begin
            freq_nxt = 16'h0000;
            if (ctrl_r[`CTRL_RUN] && !fault_r) begin
               state_nxt = init_on ? ST_INIT : ST_RAMP;
            end
         end
         ST_INIT: begin
            if (freq_out >= fmin_r) begin
               state_nxt = ST_RAMP;
            end
         end
         ST_RAMP: begin
            if (freq_out >= fmin_r) begin
               if (!fill_en) begin
                  state_nxt = ST_RUN;
               end else if (freq_out >= fpid_r) begin
                  state_nxt = ST_FILL;
                  sp_nxt    = fb_s2_r;
               end
            end
         end
         ST_FILL: begin
            if (s_step && setpoint_out < limit) begin
               sp_nxt = setpoint_out + 32'h0000_0001;
            end
            if (fb_s2_r >= limit) begin
               state_nxt = ST_RUN;
               sp_nxt    = sp_oper;
            end
         end
         ST_RUN: begin
            sp_nxt = sp_oper;
         end
         default: state_nxt = ST_IDLE;
      endcase
      if (!ctrl_r[`CTRL_RUN] || coast_req || brake_req || fault_r) begin
         state_nxt = ST_IDLE;
         freq_nxt  = 16'h0000;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r      <= ST_IDLE;
         freq_out     <= 16'h0000;
         setpoint_out <= 32'h0000_0000;
         fault_r      <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         freq_out     <= freq_nxt;
         setpoint_out <= sp_nxt;
         fault_r      <= fault_nxt;
      end
   end

   // status outputs
   assign fill_active     = (state_r == ST_FILL);
   assign pid_enable      = ctrl_r[`CTRL_CLOSED] && (state_r == ST_FILL || state_r == ST_RUN)
                            && freq_out >= fpid_r;
   assign dc_brake        = brake_req;
   assign interlock_fault = fault_r;
   assign status = {22'h00_0000, freeze_ref, setup_lsb, fill_en, fault_r, !init_on,
                    state_r[4:0]};
endmodule : pump_fill_ramp_control

// File: pump_fill_ramp_control_assertions.sv
`timescale 1ns/1ps
// fill sequencing and stop behaviour seen at the pins
module pump_fill_checks #(
   parameter logic [31:0] FILL_LIM = 32'h0000_0190
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [31:0] feedback,
   input wire logic [15:0] freq_out,
   input wire logic [31:0] setpoint_out,
   input wire logic        fill_active,
   input wire logic        pid_enable,
   input wire logic        dc_brake,
   input wire logic        interlock_fault
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence fill_entry;
      $rose(fill_active);
   endsequence
   sequence fill_hold;
      fill_active && $past(fill_active);
   endsequence
   chk_fill_gate: assert property (fill_active |-> pid_enable)
      else $error("fill running without regulation");
   chk_fill_start: assert property (fill_entry |-> freq_out != 16'h0000)
      else $error("fill entered at standstill");
   chk_fill_load: assert property (fill_entry |-> setpoint_out == feedback)
      else $error("fill setpoint not loaded from feedback");
   chk_fill_slope: assert property (fill_hold |->
      $past(setpoint_out) + 32'h1 >= setpoint_out && setpoint_out + 32'h1 >= $past(setpoint_out))
      else $error("fill setpoint moved too fast");
   // sync delay plus state update, so a few clocks of grace
   chk_fill_exit: assert property (fill_active && feedback >= FILL_LIM |-> ##[1:5] !fill_active)
      else $error("fill kept past limit");
   chk_brake_stop: assert property (dc_brake |=> freq_out == 16'h0000)
      else $error("brake did not stop output");
   chk_fault_stop: assert property (interlock_fault |=> freq_out == 16'h0000)
      else $error("interlock did not stop output");
   chk_resp_hold: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped early");
endmodule : pump_fill_checks

bind pump_fill_ramp_control pump_fill_checks chk (.aclk, .aresetn, .bvalid, .bready, .feedback,
   .freq_out, .setpoint_out, .fill_active, .pid_enable, .dc_brake, .interlock_fault);

// File: pump_sensor_model.sv
`timescale 1ns/1ps
// pipe pressure: one milli-unit every four clocks while filling below the
// setpoint, so each value stays put long enough for the input synchroniser
module pump_sensor_model #(
   parameter logic [31:0] START = 32'h0000_0064
) (
   input wire logic         aclk,
   input wire logic         aresetn,
   input wire logic         fill_active,
   input wire logic [31:0]  setpoint_out,
   output logic [31:0]      feedback
);
   logic [1:0] div_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         feedback <= START;
         div_r <= 2'h0;
      end else if (fill_active && setpoint_out > feedback) begin
         div_r <= div_r + 2'h1;
         if (div_r == 2'h3) feedback <= feedback + 32'h1;
      end
   end
endmodule : pump_sensor_model

// File: ramp_step.sv
`timescale 1ns/1ps
// fractional rate accumulator: one step pulse each time num/den crosses
module ramp_step (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        run,
   input  wire logic [31:0] num,
   input  wire logic [31:0] den,
   output logic             step
);
   logic [32:0] acc_r, acc_nxt, sum;
   logic        step_nxt;

   // at most one step per clock; faster rates saturate
   always_comb begin
      sum      = acc_r + {1'b0, num};
      acc_nxt  = acc_r;
      step_nxt = 1'b0;
      if (!run) begin
         acc_nxt = 33'h0_0000_0000;
      end else if (den == 32'h0000_0000) begin
         step_nxt = 1'b1;
      end else if (sum >= {1'b0, den}) begin
         acc_nxt  = sum - {1'b0, den};
         step_nxt = 1'b1;
      end else begin
         acc_nxt = sum;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_r <= 33'h0_0000_0000;
         step  <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         step  <= step_nxt;
      end
   end
endmodule : ramp_step

// File: test_pump_fill_ramp_control.sv
`timescale 1ns/1ps
`include "pump_fill_map.svh"
module test_pump_fill_ramp_control;
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin err_count++; \
   $display("MISMATCH %s exp %0h got %0h", nm, (e), (a)); end end
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic bready = 1'b1, rready = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, din = 8'hFF;
   logic [31:0] wdata = 32'h0, rd_data, rdata, feedback, setpoint_out;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp, last_resp;
   logic [15:0] freq_out;
   logic awready, wready, bvalid, arready, rvalid, fill_active, pid_enable;
   logic dc_brake, interlock_fault, setup_lsb;
   int err_count = 0, comparisons = 0;
   pump_fill_ramp_control #(.TENTH_CYCLES(32'h0000_000A)) uut (.aclk, .aresetn, .awvalid,
      .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
      .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .din, .feedback, .freq_out,
      .setpoint_out, .fill_active, .pid_enable, .dc_brake, .interlock_fault, .setup_lsb);
   pump_sensor_model sensor (.aclk, .aresetn, .fill_active, .setpoint_out, .feedback);
   // ***************
   // bus tasks
   // ***************
   // ready lines stay high, so every answer is taken at the edge it shows
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      last_resp = bresp;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      araddr <= a; arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd_data = rdata; last_resp = rresp;
   endtask : rd
   task automatic t_regs;
      rd(`OFS_DIN_FUNC);
      `CHK("din_rst", 32'h0003_1121, rd_data)
      rd(`OFS_FILL_RATE);
      `CHK("rate_rst", 32'h0, rd_data)
      rd(`OFS_STATUS);
      `CHK("init_off", 1'b1, rd_data[5])
      rd(8'h40);
      `CHK("unmapped", 2'b10, last_resp)
      wr(`OFS_STATUS, 32'h0);
      `CHK("ro_write", 2'b10, last_resp)
   endtask : t_regs
   task automatic t_init;
      wr(`OFS_CTRL, 32'h1);
      rd(`OFS_STATUS);
      `CHK("ramp_direct", 5'h04, rd_data[4:0])
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_INIT_TIME, 32'h0E10);
      rd(`OFS_INIT_TIME);
      `CHK("init_max", 32'h0E10, rd_data)
      wr(`OFS_INIT_TIME, 32'h14);
      wr(`OFS_CTRL, 32'h1);
      rd(`OFS_STATUS);
      `CHK("init_state", 5'h02, rd_data[4:0])
      repeat (96) @(posedge aclk);
      // 100 steps over 200 clocks, half the rate of the normal ramp
      `CHK("init_rate", 1'b1, freq_out > 16'h0028 && freq_out < 16'h003C)
      while (freq_out < 16'h0064) @(posedge aclk);
      repeat (3) @(posedge aclk);
      rd(`OFS_STATUS);
      `CHK("init_left", 1'b0, rd_data[1])
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_INIT_TIME, 32'h0);
   endtask : t_init
   task automatic t_fill_off;
      // the ramp climbs or falls toward the reference, so set it above the start freq
      wr(`OFS_FREQ_REF, 32'h0000_0190);
      for (int i = 0; i < 2; i++) begin
         wr(`OFS_FILL_RATE, i ? 32'h0 : 32'h0098_9680);
         wr(`OFS_CTRL, i ? 32'h7 : 32'h3);
         while (freq_out < 16'h0064) @(posedge aclk);
         repeat (20) @(posedge aclk);
         `CHK("no_fill", 1'b0, fill_active)
         rd(`OFS_STATUS);
         `CHK("fill_en", 1'b0, rd_data[7])
         wr(`OFS_CTRL, 32'h0);
      end
   endtask : t_fill_off
   task automatic t_fill;
      wr(`OFS_FILL_RATE, 32'h0098_9680);
      wr(`OFS_FILLED_SP, 32'h190);
      // limit is clamped to the reference maximum, so open that up first
      wr(`OFS_REF_MAX, 32'h0000_1000);
      wr(`OFS_SETPOINT1, 32'h1234);
      wr(`OFS_PID_FREQ, 32'h12C);
      wr(`OFS_CTRL, 32'h7);
      while (fill_active !== 1'b1) @(posedge aclk);
      `CHK("pid_start", 1'b1, freq_out >= 16'h012C)
      `CHK("pid_on", 1'b1, pid_enable)
      rd(`OFS_STATUS);
      `CHK("fill_en", 1'b1, rd_data[7])
      while (fill_active !== 1'b0) @(posedge aclk);
      @(posedge aclk);
      `CHK("fill_done", 1'b1, feedback >= 32'h190)
      `CHK("op_setpoint", 32'h1234, setpoint_out)
      wr(`OFS_CTRL, 32'h0);
   endtask : t_fill
   task automatic t_terminals;
      wr(`OFS_CTRL, 32'h1);
      for (int c = 3; c >= 0; c--) begin
         wr(`OFS_DIN_FUNC, {12'h000, 4'(c), 16'h1121});
         din[4] <= 1'b0;
         repeat (4) @(posedge aclk);
         `CHK("brake", c == 2, dc_brake)
         `CHK("fault", c >= 2, interlock_fault)
         `CHK("coast_stop", 16'h0000, freq_out)
         din[4] <= 1'b1;
         repeat (4) @(posedge aclk);
      end
      wr(`OFS_CTRL, 32'h0);
      // other general terminals kept at no function so only terminal 0 acts
      for (int g = 0; g < 5; g++) begin
         wr(`OFS_DIN_FUNC, {12'h000, 4'h3, 12'h000, 4'(g)});
         repeat (4) @(posedge aclk);
         `CHK("setup_lsb", g == 4, setup_lsb)
         rd(`OFS_STATUS);
         `CHK("freeze_ref", g == 2, rd_data[9])
      end
      wr(`OFS_DIN_FUNC, 32'h0003_1121);
   endtask : t_terminals
   task give_verdict;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict
   initial forever #50 aclk = ~aclk;
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_init();
      t_fill_off();
      t_fill();
      t_terminals();
      give_verdict();
   end
   // whole run is a few thousand clocks; this is far beyond it
   initial begin
      #9_000_000;
      err_count++;
      give_verdict();
   end
endmodule : test_pump_fill_ramp_control
